/* File: verilog/cas_regs.sv */
// charger alert latches, limit alerts and live condition word
`timescale 1ns/100ps
// Operation
// - state alerts set only when enabled
// - loop alerts set only when enabled
// - writing zero clears alert, one keeps
// - alerts stay set until cleared or disabled
// - bits 10,9,8: equalize, absorb, suspended entry
// - bits 7,6,5: precharge, cc/cv, thermistor pause
// - bits 4,3: timer, current threshold termination
// - bits 2,1,0: time, missing, short faults
// - loop bits 3,2: undervoltage, input limit
// - loop bits 1,0: current, voltage loops
// - limit bits: cold above, hot below threshold
// - condition word live, reads change nothing
// - bit 13 active, bit 11 tracking pin
// - bit 10 equalize pin rising edge queued
// - bit 9 driver supply above lockout
// - bit 8 invalid cell select combination
// - bit 6 all charge conditions met
// - bit 5 no resistor, bit 4 overtemperature
// - loop bits exclusive, only while charging
module cas_regs #(
   parameter logic [15:0] VALID_CELL_COUNT_SELECT_PINS = cas_pkg::VALID_CELL_CODES
) (
   input wire logic CLK_I,
   input wire logic RST_I,
   input wire logic CE_I,
   // register port behind the serial engine
   input wire logic [7:0] REG_ADDR_I,
   input wire logic REG_WR_I,
   input wire logic REG_RD_I,
   input wire logic [15:0] REG_WDATA_I,
   output logic [15:0] REG_RDATA_O,
   output logic REG_HIT_O,
   // charger state (one-hot) and raw loop activity
   input wire logic [15:0] CHARGER_STATE_I,
   input wire logic [15:0] LOOP_ACTIVITY_I,
   output logic [15:0] LOOP_STATUS_O,
   // enables held in other registers
   input wire logic [15:0] STATE_ALERT_EN_I,
   input wire logic [15:0] LOOP_ALERT_EN_I,
   input wire logic [1:0] LIMIT_ALERT_EN_I,
   // thermistor result and limits, two's complement
   input wire logic [15:0] THERM_RATIO_I,
   input wire logic [15:0] COLD_BATTERY_THRESHOLD_I,
   input wire logic [15:0] HOT_BATTERY_THRESHOLD_I,
   // live conditions
   input wire logic CHARGER_ACTIVE_I,
   input wire logic MPPT_PIN_I,
   input wire logic EQUALIZE_REQUEST_PIN_I,
   input wire logic DRV_SUPPLY_OK_I,
   input wire logic [3:0] CELL_COUNT_SELECT_PINS_I,
   input wire logic CHARGE_PERMITTED_I,
   input wire logic MISSING_TIMING_RESISTOR_I,
   input wire logic THERMAL_SHUTDOWN_I,
   output logic ALERT_PENDING_O
);
   // ----------------------------------------------------------------
   // helpers
   // ----------------------------------------------------------------
   // highest-priority bit only, so loop indications never overlap
   function automatic logic [15:0] top_bit(input logic [15:0] v);
      logic [15:0] r;
      r = '0;
      for (int i = 0; i < 16; i++) begin
         if (v[i]) begin
            r = '0;
            r[i] = 1'b1;
         end
      end
      return r;
   endfunction

   function automatic logic is_ofs(input logic [7:0] a, input logic [7:0] ofs);
      return a == ofs;
   endfunction

   cas_bank_if #(.W(16)) state_bus ();
   cas_bank_if #(.W(16)) loop_bus ();
   cas_bank_if #(.W(16)) limit_bus ();

   logic charging;
   logic [15:0] loop_q;
   logic [15:0] next_loop_q;
   logic [15:0] limit_src;
   logic [15:0] sys_word;
   logic [15:0] rd_value;
   logic rd_hit;
   logic [15:0] next_rdata;
   logic next_hit;

   // ----------------------------------------------------------------
   // loop status qualification
   // ----------------------------------------------------------------
   always_comb begin
      charging = CHARGER_STATE_I[cas_pkg::ST_EQUALIZE] |
                 CHARGER_STATE_I[cas_pkg::ST_ABSORB] |
                 CHARGER_STATE_I[cas_pkg::ST_PRECHARGE] |
                 CHARGER_STATE_I[cas_pkg::ST_CCCV];
      next_loop_q = charging ? top_bit(LOOP_ACTIVITY_I & cas_pkg::LOOP_ALERT_MASK) : '0;
   end

   always_ff @(posedge CLK_I or posedge RST_I) begin
      if (RST_I) begin
         loop_q <= cas_pkg::ALERT_RESET;
      end else if (CE_I) begin
         loop_q <= next_loop_q;
      end
   end

   assign LOOP_STATUS_O = loop_q;

   // ----------------------------------------------------------------
   // limit comparison
   // ----------------------------------------------------------------
   // hot battery pulls the ratio down, so hot trips below its limit
   always_comb begin
      limit_src = '0;
      limit_src[cas_pkg::LM_COLD] =
         $signed(THERM_RATIO_I) > $signed(COLD_BATTERY_THRESHOLD_I);
      limit_src[cas_pkg::LM_HOT] =
         $signed(THERM_RATIO_I) < $signed(HOT_BATTERY_THRESHOLD_I);
   end

   // ----------------------------------------------------------------
   // alert banks
   // ----------------------------------------------------------------
   // state entries feed the state bank bit for bit
   assign state_bus.src = CHARGER_STATE_I;
   assign state_bus.en = STATE_ALERT_EN_I;
   assign state_bus.wr = CE_I & REG_WR_I & is_ofs(REG_ADDR_I, cas_pkg::STATE_ALERT_OFS);
   assign state_bus.wdata = REG_WDATA_I;

   // loop activations come from the qualified loop word
   assign loop_bus.src = loop_q;
   assign loop_bus.en = LOOP_ALERT_EN_I;
   assign loop_bus.wr = CE_I & REG_WR_I & is_ofs(REG_ADDR_I, cas_pkg::LOOP_ALERT_OFS);
   assign loop_bus.wdata = REG_WDATA_I;

   assign limit_bus.src = limit_src;
   assign limit_bus.en = {14'h0000, LIMIT_ALERT_EN_I};
   assign limit_bus.wr = CE_I & REG_WR_I & is_ofs(REG_ADDR_I, cas_pkg::LIMIT_ALERT_OFS);
   assign limit_bus.wdata = REG_WDATA_I;

   cas_alert_bank #(.W(16), .MASK(cas_pkg::STATE_ALERT_MASK)) u_state_bank (
      .clk_i(CLK_I),
      .rst_i(RST_I),
      .ce_i(CE_I),
      .bus(state_bus)
   );

   cas_alert_bank #(.W(16), .MASK(cas_pkg::LOOP_ALERT_MASK)) u_loop_bank (
      .clk_i(CLK_I),
      .rst_i(RST_I),
      .ce_i(CE_I),
      .bus(loop_bus)
   );

   cas_alert_bank #(.W(16), .MASK(cas_pkg::LIMIT_ALERT_MASK)) u_limit_bank (
      .clk_i(CLK_I),
      .rst_i(RST_I),
      .ce_i(CE_I),
      .bus(limit_bus)
   );

   // ----------------------------------------------------------------
   // live condition word
   // ----------------------------------------------------------------
   cas_status #(.VALID_CELL_COUNT_SELECT_PINS(VALID_CELL_COUNT_SELECT_PINS)) u_status (
      .clk_i(CLK_I),
      .rst_i(RST_I),
      .ce_i(CE_I),
      .charger_active_i(CHARGER_ACTIVE_I),
      .mppt_pin_i(MPPT_PIN_I),
      .equalize_request_pin_i(EQUALIZE_REQUEST_PIN_I),
      .equalize_entered_i(CHARGER_STATE_I[cas_pkg::ST_EQUALIZE]),
      .drv_supply_ok_i(DRV_SUPPLY_OK_I),
      .cell_count_select_pins_i(CELL_COUNT_SELECT_PINS_I),
      .charge_permitted_i(CHARGE_PERMITTED_I),
      .missing_timing_resistor_i(MISSING_TIMING_RESISTOR_I),
      .thermal_shutdown_i(THERMAL_SHUTDOWN_I),
      .word_o(sys_word)
   );

   // ----------------------------------------------------------------
   // register read path
   // ----------------------------------------------------------------
   always_comb begin
      rd_hit = 1'b1;
      if (is_ofs(REG_ADDR_I, cas_pkg::LIMIT_ALERT_OFS)) begin
         rd_value = limit_bus.flags;
      end else if (is_ofs(REG_ADDR_I, cas_pkg::STATE_ALERT_OFS)) begin
         rd_value = state_bus.flags;
      end else if (is_ofs(REG_ADDR_I, cas_pkg::LOOP_ALERT_OFS)) begin
         rd_value = loop_bus.flags;
      end else if (is_ofs(REG_ADDR_I, cas_pkg::SYS_COND_OFS)) begin
         rd_value = sys_word & cas_pkg::SYS_COND_MASK;
      end else begin
         rd_value = '0;
         rd_hit = 1'b0;
      end
      next_rdata = REG_RDATA_O;
      next_hit = REG_HIT_O;
      if (REG_RD_I) begin
         next_rdata = rd_value;
         next_hit = rd_hit;
      end
   end

   always_ff @(posedge CLK_I or posedge RST_I) begin
      if (RST_I) begin
         REG_RDATA_O <= cas_pkg::ALERT_RESET;
         REG_HIT_O <= 1'b0;
      end else if (CE_I) begin
         REG_RDATA_O <= next_rdata;
         REG_HIT_O <= next_hit;
      end
   end

   // combined pending level for the alert pin logic outside
   assign ALERT_PENDING_O = |{state_bus.flags, loop_bus.flags, limit_bus.flags};

   // ----------------------------------------------------------------
   // checks
   // ----------------------------------------------------------------
   a_loop_exclusive: assert property (
      @(posedge CLK_I) disable iff (RST_I)
      $onehot0(loop_q))
      else $error("loop status bits overlap");
   a_loop_charging: assert property (
      @(posedge CLK_I) disable iff (RST_I)
      CE_I && !charging |=> loop_q == '0)
      else $error("loop status active outside charging");
   a_state_enable: assert property (
      @(posedge CLK_I) disable iff (RST_I)
      CE_I |=> (state_bus.flags & ~$past(STATE_ALERT_EN_I)) == '0)
      else $error("state alert set while disabled");
   a_loop_enable: assert property (
      @(posedge CLK_I) disable iff (RST_I)
      CE_I |=> (loop_bus.flags & ~$past(LOOP_ALERT_EN_I)) == '0)
      else $error("loop alert set while disabled");
   a_equalize_entry: assert property (
      @(posedge CLK_I) disable iff (RST_I)
      CE_I ##1 CE_I && $rose(CHARGER_STATE_I[cas_pkg::ST_EQUALIZE]) &&
      STATE_ALERT_EN_I[cas_pkg::ST_EQUALIZE] |=> state_bus.flags[cas_pkg::ST_EQUALIZE])
      else $error("equalize entry not latched");
   a_cold_limit: assert property (
      @(posedge CLK_I) disable iff (RST_I)
      CE_I ##1 CE_I && $rose(limit_src[cas_pkg::LM_COLD]) &&
      LIMIT_ALERT_EN_I[cas_pkg::LM_COLD] |=> limit_bus.flags[cas_pkg::LM_COLD])
      else $error("cold limit alert missing");
   a_status_follows: assert property (
      @(posedge CLK_I) disable iff (RST_I)
      CE_I |=> sys_word[cas_pkg::SC_CHARGER_ACTIVE] == $past(CHARGER_ACTIVE_I) &&
      sys_word[cas_pkg::SC_THERMAL_SHDN] == $past(THERMAL_SHUTDOWN_I))
      else $error("condition word not live");
   a_read_value: assert property (
      @(posedge CLK_I) disable iff (RST_I)
      CE_I && REG_RD_I && is_ofs(REG_ADDR_I, cas_pkg::STATE_ALERT_OFS) |=>
      REG_RDATA_O == $past(state_bus.flags))
      else $error("read data does not match alerts");
   a_unmapped_zero: assert property (
      @(posedge CLK_I) disable iff (RST_I)
      CE_I && REG_RD_I && !rd_hit |=> REG_RDATA_O == '0 && !REG_HIT_O)
      else $error("unmapped read not zero");
   a_hot_limit: assert property (
      @(posedge CLK_I) disable iff (RST_I)
      CE_I ##1 CE_I && $rose(limit_src[cas_pkg::LM_HOT]) &&
      LIMIT_ALERT_EN_I[cas_pkg::LM_HOT] |=> limit_bus.flags[cas_pkg::LM_HOT])
      else $error("hot limit alert missing");
   a_uv_loop_entry: assert property (
      @(posedge CLK_I) disable iff (RST_I)
      CE_I ##1 CE_I && $rose(loop_q[cas_pkg::LP_INPUT_UV]) &&
      LOOP_ALERT_EN_I[cas_pkg::LP_INPUT_UV] |=> loop_bus.flags[cas_pkg::LP_INPUT_UV])
      else $error("undervoltage loop alert missing");
   a_volt_loop_entry: assert property (
      @(posedge CLK_I) disable iff (RST_I)
      CE_I ##1 CE_I && $rose(loop_q[cas_pkg::LP_BAT_VOLTAGE]) &&
      LOOP_ALERT_EN_I[cas_pkg::LP_BAT_VOLTAGE] |=> loop_bus.flags[cas_pkg::LP_BAT_VOLTAGE])
      else $error("voltage loop alert missing");
   a_state_clear: assert property (
      @(posedge CLK_I) disable iff (RST_I)
      state_bus.wr && !REG_WDATA_I[cas_pkg::ST_BAT_SHORT] &&
      !CHARGER_STATE_I[cas_pkg::ST_BAT_SHORT] |=> !state_bus.flags[cas_pkg::ST_BAT_SHORT])
      else $error("zero write left state alert set");
   a_state_sticky: assert property (
      @(posedge CLK_I) disable iff (RST_I)
      CE_I && !state_bus.wr && state_bus.flags[cas_pkg::ST_SUSPENDED] &&
      STATE_ALERT_EN_I[cas_pkg::ST_SUSPENDED] |=> state_bus.flags[cas_pkg::ST_SUSPENDED])
      else $error("state alert dropped on its own");
   a_sys_read_mask: assert property (
      @(posedge CLK_I) disable iff (RST_I)
      CE_I && REG_RD_I && is_ofs(REG_ADDR_I, cas_pkg::SYS_COND_OFS) |=>
      REG_HIT_O && (REG_RDATA_O & ~cas_pkg::SYS_COND_MASK) == '0)
      else $error("undefined condition bit read as one");
endmodule

/* File: verilog/cas_pkg.sv */
// constants for the charger alert and status register block
package cas_pkg;
   // ----------------------------------------------------------------
   // register offsets
   // ----------------------------------------------------------------
   localparam logic [7:0] LIMIT_ALERT_OFS = 8'h36;
   localparam logic [7:0] STATE_ALERT_OFS = 8'h37;
   localparam logic [7:0] LOOP_ALERT_OFS = 8'h38;
   localparam logic [7:0] SYS_COND_OFS = 8'h39;
   // ----------------------------------------------------------------
   // reset values and implemented-bit masks
   // ----------------------------------------------------------------
   localparam logic [15:0] ALERT_RESET = 16'h0000;
   localparam logic [15:0] STATE_ALERT_MASK = 16'h07FF;
   localparam logic [15:0] LOOP_ALERT_MASK = 16'h000F;
   localparam logic [15:0] LIMIT_ALERT_MASK = 16'h0003;
   localparam logic [15:0] SYS_COND_MASK = 16'h2F70;
   localparam logic [15:0] VALID_CELL_CODES = 16'h1FFE;
   // ----------------------------------------------------------------
   // charger state bit positions
   // ----------------------------------------------------------------
   localparam int ST_EQUALIZE = 10;
   localparam int ST_ABSORB = 9;
   localparam int ST_SUSPENDED = 8;
   localparam int ST_PRECHARGE = 7;
   localparam int ST_CCCV = 6;
   localparam int ST_THERM_PAUSE = 5;
   localparam int ST_TIMER_TERM = 4;
   localparam int ST_CX_TERM = 3;
   localparam int ST_MAX_TIME_FLT = 2;
   localparam int ST_BAT_MISSING = 1;
   localparam int ST_BAT_SHORT = 0;
   // ----------------------------------------------------------------
   // loop, limit and system condition bit positions
   // ----------------------------------------------------------------
   localparam int LP_INPUT_UV = 3;
   localparam int LP_INPUT_ILIM = 2;
   localparam int LP_CHG_CURRENT = 1;
   localparam int LP_BAT_VOLTAGE = 0;
   localparam int LM_COLD = 1;
   localparam int LM_HOT = 0;
   localparam int SC_CHARGER_ACTIVE = 13;
   localparam int SC_MPPT_PIN = 11;
   localparam int SC_EQ_QUEUED = 10;
   localparam int SC_DRV_SUPPLY_OK = 9;
   localparam int SC_CELL_ERROR = 8;
   localparam int SC_CHARGE_PERMITTED = 6;
   localparam int SC_NO_TIMING_RES = 5;
   localparam int SC_THERMAL_SHDN = 4;
endpackage

/* File: verilog/cas_bank_if.sv */
// link between the register front end and one alert latch bank
`timescale 1ns/100ps
interface cas_bank_if #(parameter int W = 16);
   logic [W-1:0] src;
   logic [W-1:0] en;
   logic wr;
   logic [W-1:0] wdata;
   logic [W-1:0] flags;
   modport ctrl (output src, output en, output wr, output wdata, input flags);
   modport bank (input src, input en, input wr, input wdata, output flags);
endinterface

/* File: verilog/cas_alert_bank.sv */
// sticky alert latch bank with entry detection and write-zero clear
`timescale 1ns/100ps
module cas_alert_bank #(
   parameter int W = 16,
   parameter logic [W-1:0] MASK = {W{1'b1}}
) (
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic ce_i,
   cas_bank_if.bank bus
);
   logic [W-1:0] src_q;
   logic [W-1:0] flags;
   logic [W-1:0] next_src_q;
   logic [W-1:0] next_flags;
   logic [W-1:0] entry;
   logic [W-1:0] clr;

   always_comb begin
      next_src_q = bus.src;
      entry = bus.src & ~src_q;
      clr = bus.wr ? ~bus.wdata : '0;
      // enable gates set; sticky until clear or disable
      next_flags = ((flags & ~clr) | entry) & bus.en & MASK;
   end

   always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         src_q <= '0;
         flags <= '0;
      end else if (ce_i) begin
         src_q <= next_src_q;
         flags <= next_flags;
      end
   end

   assign bus.flags = flags;

   a_entry_sets: assert property (
      @(posedge clk_i) disable iff (rst_i)
      ce_i && |(entry & bus.en & MASK) |=>
      ((flags & $past(entry & bus.en & MASK)) == $past(entry & bus.en & MASK)))
      else $error("entry event did not set its alert");
   a_sticky_hold: assert property (
      @(posedge clk_i) disable iff (rst_i)
      ce_i && !bus.wr |=> ((flags & $past(flags & bus.en)) == $past(flags & bus.en)))
      else $error("alert fell without clear or disable");
   a_zero_clears: assert property (
      @(posedge clk_i) disable iff (rst_i)
      ce_i && bus.wr |=>
      ((flags & $past(~bus.wdata & ~entry)) == '0))
      else $error("zero write did not clear alert");
   a_enable_gates: assert property (
      @(posedge clk_i) disable iff (rst_i)
      ce_i |=> ((flags & ~$past(bus.en)) == '0))
      else $error("alert set while disabled");
   a_unused_zero: assert property (
      @(posedge clk_i) disable iff (rst_i)
      (flags & ~MASK) == '0)
      else $error("undefined alert bit set");
endmodule

/* File: verilog/cas_status.sv */
// live system condition word with equalize request capture
`timescale 1ns/100ps
module cas_status #(
   parameter logic [15:0] VALID_CELL_COUNT_SELECT_PINS = cas_pkg::VALID_CELL_CODES
) (
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic ce_i,
   input wire logic charger_active_i,
   input wire logic mppt_pin_i,
   input wire logic equalize_request_pin_i,
   input wire logic equalize_entered_i,
   input wire logic drv_supply_ok_i,
   input wire logic [3:0] cell_count_select_pins_i,
   input wire logic charge_permitted_i,
   input wire logic missing_timing_resistor_i,
   input wire logic thermal_shutdown_i,
   output logic [15:0] word_o
);
   logic eq_pin_q;
   logic eq_queued;
   logic next_eq_pin_q;
   logic next_eq_queued;
   logic [15:0] next_word;

   always_comb begin
      next_eq_pin_q = equalize_request_pin_i;
      next_eq_queued = eq_queued;
      if (equalize_entered_i) begin
         next_eq_queued = 1'b0;
      end
      // rising edge queues equalize, edge wins over start
      if (equalize_request_pin_i && !eq_pin_q) begin
         next_eq_queued = 1'b1;
      end
      next_word = '0;
      next_word[cas_pkg::SC_CHARGER_ACTIVE] = charger_active_i;
      next_word[cas_pkg::SC_MPPT_PIN] = mppt_pin_i;
      next_word[cas_pkg::SC_EQ_QUEUED] = next_eq_queued;
      next_word[cas_pkg::SC_DRV_SUPPLY_OK] = drv_supply_ok_i;
      next_word[cas_pkg::SC_CELL_ERROR] = ~VALID_CELL_COUNT_SELECT_PINS[cell_count_select_pins_i];
      next_word[cas_pkg::SC_CHARGE_PERMITTED] = charge_permitted_i;
      next_word[cas_pkg::SC_NO_TIMING_RES] = missing_timing_resistor_i;
      next_word[cas_pkg::SC_THERMAL_SHDN] = thermal_shutdown_i;
   end

   always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         eq_pin_q <= 1'b0;
         eq_queued <= 1'b0;
         word_o <= cas_pkg::ALERT_RESET;
      end else if (ce_i) begin
         eq_pin_q <= next_eq_pin_q;
         eq_queued <= next_eq_queued;
         word_o <= next_word;
      end
   end

   a_eq_edge_queues: assert property (
      @(posedge clk_i) disable iff (rst_i)
      ce_i && equalize_request_pin_i && !eq_pin_q |=> word_o[cas_pkg::SC_EQ_QUEUED])
      else $error("equalize edge not queued");
   a_cell_error: assert property (
      @(posedge clk_i) disable iff (rst_i)
      ce_i |=> (word_o[cas_pkg::SC_CELL_ERROR] ==
                !VALID_CELL_COUNT_SELECT_PINS[$past(cell_count_select_pins_i)]))
      else $error("cell error mismatch");
endmodule

/* File: verification/cas_src_model.sv */
// charger state and loop activity source standing in for the charger core
`timescale 1ns/100ps
module cas_src_model (
   input wire logic [3:0] state_sel_i,
   input wire logic [3:0] loop_sel_i,
   output logic [15:0] state_o,
   output logic [15:0] loop_o
);
   // ----------------------------------------------------------------
   // decoders
   // ----------------------------------------------------------------
   // the core holds exactly one state, or none for codes above 10
   always_comb begin
      state_o = 16'h0000;
      loop_o = 16'h0000;
      if (state_sel_i < 4'hB) begin
         state_o[state_sel_i] = 1'b1;
      end
      // raw loops may overlap; gating and priority are the block's job
      if (loop_sel_i < 4'h4) begin
         loop_o[loop_sel_i[1:0]] = 1'b1;
      end else if (loop_sel_i != 4'hF) begin
         // codes 4 to 14 show their own low bits, so several loops at once for all but 4 and 8
         loop_o = {12'h000, loop_sel_i};
      end
   end
endmodule

/* File: verification/tb_top.sv */
// self-checking bench for the charger alert and status registers
`timescale 1ns/100ps
module tb_top;
   logic clk, rst, ce, wr, rd, eq_pin, chg_act, mppt, drv_ok, permit, no_res, thermal;
   logic hit, pending, rd_seen;
   logic [1:0] lim_en;
   logic [3:0] state_sel, loop_sel, cell_count_select_pins;
   logic [7:0] addr;
   logic [9:0] rv;
   logic [15:0] wdata, rdata, loop_status, st_en, lp_en, ratio, cold, hot, state, loop;
   logic [15:0] en_v, exp_st, exp_lp, exp_sys;
   logic [16:0] exp_q[$];
   int miscompares, checks, cycles, seed, i;

   cas_src_model i_cas_src_model (
      .state_sel_i(state_sel),
      .loop_sel_i(loop_sel),
      .state_o(state),
      .loop_o(loop)
   );
   cas_regs i_cas_regs (
      .CLK_I(clk),
      .RST_I(rst),
      .CE_I(ce),
      .REG_ADDR_I(addr),
      .REG_WR_I(wr),
      .REG_RD_I(rd),
      .REG_WDATA_I(wdata),
      .REG_RDATA_O(rdata),
      .REG_HIT_O(hit),
      .CHARGER_STATE_I(state),
      .LOOP_ACTIVITY_I(loop),
      .LOOP_STATUS_O(loop_status),
      .STATE_ALERT_EN_I(st_en),
      .LOOP_ALERT_EN_I(lp_en),
      .LIMIT_ALERT_EN_I(lim_en),
      .THERM_RATIO_I(ratio),
      .COLD_BATTERY_THRESHOLD_I(cold),
      .HOT_BATTERY_THRESHOLD_I(hot),
      .CHARGER_ACTIVE_I(chg_act),
      .MPPT_PIN_I(mppt),
      .EQUALIZE_REQUEST_PIN_I(eq_pin),
      .DRV_SUPPLY_OK_I(drv_ok),
      .CELL_COUNT_SELECT_PINS_I(cell_count_select_pins),
      .CHARGE_PERMITTED_I(permit),
      .MISSING_TIMING_RESISTOR_I(no_res),
      .THERMAL_SHUTDOWN_I(thermal),
      .ALERT_PENDING_O(pending)
   );

   // ----------------------------------------------------------------
   // clock, watchdog and read monitor
   // ----------------------------------------------------------------
   initial begin
      clk = 1'b0;
      forever #5 clk = ~clk;
   end

   // the whole run needs about 110 cycles; a hang is cut off well after that
   always @(posedge clk) begin
      rd_seen <= rd & ce;
      cycles <= cycles + 1;
      if (cycles >= 2000) begin
         miscompares++;
         summarize();
      end
   end

   always @(negedge clk) begin
      if (rd_seen === 1'b1 && exp_q.size() > 0) begin
         check({hit, rdata}, exp_q.pop_front());
      end
   end

   // ----------------------------------------------------------------
   // tasks
   // ----------------------------------------------------------------
   task automatic check(input logic [16:0] got, input logic [16:0] exp);
      checks++;
      if (got !== exp) begin
         miscompares++;
         $display("BAD %0t got %h expected %h", $time, got, exp);
      end
   endtask

   task automatic check_out(input logic [15:0] got, input logic [15:0] exp);
      check({1'b0, got}, {1'b0, exp});
   endtask

   task automatic summarize();
      $display("checks %0d miscompares %0d", checks, miscompares);
      if (miscompares == 0 && checks > 0) begin
         $display("Test passed");
      end else begin
         $display("Test failed");
      end
      $finish;
   endtask

   task automatic tick(input int n);
      repeat (n) @(posedge clk);
   endtask

   // one write or read; strobes drop at the next edge so ops never overlap
   task automatic op(input logic w, input logic [7:0] a, input logic [15:0] d,
         input logic [16:0] e);
      @(posedge clk);
      wr <= w;
      rd <= ~w;
      addr <= a;
      wdata <= d;
      if (!w) begin
         exp_q.push_back(e);
      end
      @(posedge clk);
      wr <= 1'b0;
      rd <= 1'b0;
   endtask

   task automatic rdc(input logic [7:0] a, input logic [15:0] e);
      op(1'b0, a, 16'h0000, {1'b1, e});
   endtask

   // ----------------------------------------------------------------
   // main sequence
   // ----------------------------------------------------------------
   initial begin
      seed = 84;
      {wr, rd, eq_pin, chg_act, mppt, drv_ok, permit, no_res, thermal, rd_seen} = 10'h000;
      ce = 1'b1;
      rst = 1'b1;
      addr = 8'h00;
      wdata = 16'h0000;
      st_en = 16'h07FF;
      lp_en = 16'h000F;
      lim_en = 2'h3;
      ratio = 16'h0000;
      cold = 16'h0064;
      hot = 16'hFF9C;
      state_sel = 4'hF;
      loop_sel = 4'hF;
      cell_count_select_pins = 4'h0;
      cycles = 0;
      miscompares = 0;
      checks = 0;
      repeat (2) @(posedge clk);
      rst <= 1'b0;
      rdc(cas_pkg::STATE_ALERT_OFS, 16'h0000);
      rdc(cas_pkg::LOOP_ALERT_OFS, 16'h0000);
      rdc(cas_pkg::SYS_COND_OFS, 16'h0100);
      op(1'b0, 8'h00, 16'h0000, 17'h00000);
      for (i = 0; i < 6; i++) begin
         rv = 10'($random(seed));
         {chg_act, mppt, drv_ok, permit, no_res, thermal, cell_count_select_pins} <= rv;
         exp_sys = {2'h0, rv[9], 1'b0, rv[8], 1'b0, rv[7],
            rv[3:0] == 4'h0 || rv[3:0] > 4'hC, 1'b0, rv[6:4], 4'h0};
         rdc(cas_pkg::SYS_COND_OFS, exp_sys);
      end
      op(1'b1, cas_pkg::SYS_COND_OFS, 16'h0000, 17'h00000);
      rdc(cas_pkg::SYS_COND_OFS, exp_sys);
      eq_pin <= 1'b1;
      tick(2);
      exp_sys[10] = 1'b1;
      rdc(cas_pkg::SYS_COND_OFS, exp_sys);
      eq_pin <= 1'b0;
      rdc(cas_pkg::SYS_COND_OFS, exp_sys);
      en_v = 16'($random(seed));
      st_en <= en_v;
      exp_st = 16'h0000;
      for (i = 0; i < 11; i++) begin
         state_sel <= 4'(i);
         exp_st[i] = en_v[i];
         rdc(cas_pkg::STATE_ALERT_OFS, exp_st);
      end
      exp_sys[10] = 1'b0;
      rdc(cas_pkg::SYS_COND_OFS, exp_sys);
      op(1'b1, cas_pkg::STATE_ALERT_OFS, 16'hFFFE, 17'h00000);
      exp_st[0] = 1'b0;
      rdc(cas_pkg::STATE_ALERT_OFS, exp_st);
      // a fresh entry lands on the same edge as an all-zero write
      @(posedge clk);
      state_sel <= 4'h0;
      wr <= 1'b1;
      addr <= cas_pkg::STATE_ALERT_OFS;
      wdata <= 16'h0000;
      @(posedge clk);
      wr <= 1'b0;
      rdc(cas_pkg::STATE_ALERT_OFS, {15'h0000, en_v[0]});
      st_en <= 16'h0000;
      rdc(cas_pkg::STATE_ALERT_OFS, 16'h0000);
      st_en <= 16'h07FF;
      state_sel <= 4'h1;
      rdc(cas_pkg::STATE_ALERT_OFS, 16'h0002);
      check_out({15'h0000, pending}, 16'h0001);
      ce <= 1'b0;
      op(1'b1, cas_pkg::STATE_ALERT_OFS, 16'h0000, 17'h00000);
      ce <= 1'b1;
      rdc(cas_pkg::STATE_ALERT_OFS, 16'h0002);
      op(1'b1, cas_pkg::STATE_ALERT_OFS, 16'h0000, 17'h00000);
      rdc(cas_pkg::STATE_ALERT_OFS, 16'h0000);
      check_out({15'h0000, pending}, 16'h0000);
      en_v = 16'($random(seed));
      lp_en <= en_v;
      state_sel <= 4'h6;
      exp_lp = 16'h0000;
      for (i = 0; i < 4; i++) begin
         loop_sel <= 4'(i);
         exp_lp[i] = en_v[i];
         tick(1);
         rdc(cas_pkg::LOOP_ALERT_OFS, exp_lp);
         check_out(loop_status, 16'h0001 << i);
      end
      // two raw loops at once: only the higher one may show
      loop_sel <= 4'h6;
      tick(2);
      check_out(loop_status, 16'h0004);
      state_sel <= 4'h8;
      loop_sel <= 4'h0;
      op(1'b1, cas_pkg::LOOP_ALERT_OFS, 16'h0000, 17'h00000);
      rdc(cas_pkg::LOOP_ALERT_OFS, 16'h0000);
      check_out(loop_status, 16'h0000);
      ratio <= 16'h00C8;
      tick(2);
      ratio <= 16'hFF38;
      tick(2);
      rdc(cas_pkg::LIMIT_ALERT_OFS, 16'h0003);
      op(1'b1, cas_pkg::LIMIT_ALERT_OFS, 16'hFFFD, 17'h00000);
      rdc(cas_pkg::LIMIT_ALERT_OFS, 16'h0001);
      tick(3);
      if (exp_q.size() != 0) begin
         miscompares++;
      end
      summarize();
   end
endmodule
